// *** ddcs_ctrl.sv ***
// Purpose: Filter source selection, oscillator load control and
//          decimation configuration for four down-converter channels.
// Assumes: Converter samples arrive on core_clk; frequency pick pins
//          are asynchronous and are synchronised here.
// Notes:   Filter arithmetic and oscillator words live elsewhere.
// How it works
// - Source codes 00/01 pick one channel: filters 0,2 take A on 00, 1,3 B.
// - Source code 10 feeds the filter (A + B) / 2.
// - Source code 11 feeds the filter (A - B) / 2.
// - A 0-to-1 on an oscillator's load bit loads its four frequencies.
// - A 0-to-1 on the shared load bit loads every oscillator at once.
// - Negative-image pick acts only while complex decimation is on.
// - Phase mode 0 runs oscillators phase continuous, 1 phase coherent.
// - Low-latency mode sends raw samples past all digital processing.
// - With autoload off, a pin frequency switch causes no load pulse.
// - Pick source bit 0 takes the active frequency from pins, 1 from regs.
// - Each 2-bit pick field chooses the active frequency; filter 2 resets 10.
// - Decimation code 0000 bypasses, 0001 is /2, up to 1111 as /32768.
// - Per-filter factors apply only with unequal decimation, else common.
// - The complex enable bit picks real (0) or complex (1) decimation.
`timescale 1ns/10ps
module ddcs_ctrl
  import ddcs_pkg::*;
#(
  parameter int SMP_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Serial register port
  input wire logic spi_sclk,
  input wire logic spi_sen_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Frequency pick pins, two per filter
  input wire logic [7:0] pin_freq_pick,
  // Converter samples
  input wire logic [SMP_W-1:0] chan_a_smp,
  input wire logic [SMP_W-1:0] chan_b_smp,
  // Filter inputs and low-latency bypass
  output logic [3:0][SMP_W-1:0] filt_smp_r,
  output logic [SMP_W-1:0] bypass_a_r,
  output logic [SMP_W-1:0] bypass_b_r,
  // Oscillator load pulses and configuration
  output logic [3:0] osc_load_r,
  output ddcs_cfg_t cfg_r
);

  // Half of a sign-extended sum or difference, never overflows
  function automatic logic [SMP_W-1:0] half_mix(input logic [SMP_W-1:0] a,
      input logic [SMP_W-1:0] b, input logic diff);
    logic [SMP_W:0] ea, eb, r;
    ea = {a[SMP_W-1], a};
    eb = {b[SMP_W-1], b};
    r = diff ? ea - eb : ea + eb;
    return r[SMP_W:1];
  endfunction

  // Sample for one filter; even filters own A, odd ones own B
  function automatic logic [SMP_W-1:0] pick_src(input logic [1:0] code,
      input logic odd, input logic [SMP_W-1:0] a, input logic [SMP_W-1:0] b);
    logic [SMP_W-1:0] r;
    r = '0;
    case (ddcs_src_t'(code))
      SRC_OWN: r = odd ? b : a;
      SRC_OTHER: r = odd ? a : b;
      SRC_HALF_SUM: r = half_mix(a, b, 1'b0);
      SRC_HALF_DIFF: r = half_mix(a, b, 1'b1);
      default: r = '0;
    endcase
    return r;
  endfunction

  logic [14:0] rd_addr;
  ddcs_wr_t wr;
  logic wr_stb;
  logic [7:0] rd_data;

  // Serial port front end
  ddcs_spi_slave u_spi (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .spi_sclk(spi_sclk),
    .spi_sen_n(spi_sen_n),
    .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo),
    .spi_sdo_oe(spi_sdo_oe),
    .rd_data(rd_data),
    .rd_addr_r(rd_addr),
    .wr_r(wr),
    .wr_stb_r(wr_stb)
  );

  logic [7:0] mode_r, mode_nxt, src_r, src_nxt, load_r, load_nxt;
  logic [7:0] misc_r, misc_nxt, pick_r, pick_nxt;
  logic [7:0] declo_r, declo_nxt, dechi_r, dechi_nxt, dcom_r, dcom_nxt;
  logic [3:0] load_edge;

  // Register bank; reserved bits kept as written
  always_comb begin
    mode_nxt = mode_r;
    src_nxt = src_r;
    load_nxt = load_r;
    misc_nxt = misc_r;
    pick_nxt = pick_r;
    declo_nxt = declo_r;
    dechi_nxt = dechi_r;
    dcom_nxt = dcom_r;
    load_edge = 4'h0;
    if (wr_stb) begin
      case (wr.addr)
        OFF_OUTPUT_MODE: mode_nxt = wr.data;
        OFF_SOURCE_SEL: src_nxt = wr.data;
        OFF_OSC_LOAD: begin
          load_nxt = wr.data;
          // New value against stored value gives the 0-to-1 edges
          load_edge = wr.data[OSC_LOAD_LSB+:4] &
                      ~load_r[OSC_LOAD_LSB+:4];
        end
        OFF_OSC_MISC: begin
          misc_nxt = wr.data;
          if (wr.data[COMMON_LOAD_BIT] && !misc_r[COMMON_LOAD_BIT]) begin
            load_edge = 4'hf;
          end
        end
        OFF_FREQ_PICK: pick_nxt = wr.data;
        OFF_DECIM_LOW: declo_nxt = wr.data;
        OFF_DECIM_HIGH: dechi_nxt = wr.data;
        OFF_DECIM_COMMON: dcom_nxt = wr.data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      mode_r <= RST_OUTPUT_MODE;
      src_r <= RST_SOURCE_SEL;
      load_r <= RST_OSC_LOAD;
      misc_r <= RST_OSC_MISC;
      pick_r <= RST_FREQ_PICK;
      declo_r <= RST_DECIM_LOW;
      dechi_r <= RST_DECIM_HIGH;
      dcom_r <= RST_DECIM_COMMON;
    end else begin
      mode_r <= mode_nxt;
      src_r <= src_nxt;
      load_r <= load_nxt;
      misc_r <= misc_nxt;
      pick_r <= pick_nxt;
      declo_r <= declo_nxt;
      dechi_r <= dechi_nxt;
      dcom_r <= dcom_nxt;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    case (rd_addr)
      OFF_OUTPUT_MODE: rd_data = mode_r;
      OFF_SOURCE_SEL: rd_data = src_r;
      OFF_OSC_LOAD: rd_data = load_r;
      OFF_OSC_MISC: rd_data = misc_r;
      OFF_FREQ_PICK: rd_data = pick_r;
      OFF_DECIM_LOW: rd_data = declo_r;
      OFF_DECIM_HIGH: rd_data = dechi_r;
      OFF_DECIM_COMMON: rd_data = dcom_r;
      default: rd_data = 8'h00;
    endcase
  end

  logic [7:0] pin_s1_r, pin_s2_r, pin_d_r;
  logic [3:0] pin_change;
  logic reg_pick, autoload_off, low_lat, complex_on;

  assign reg_pick = misc_r[REG_PICK_BIT];
  assign autoload_off = misc_r[AUTOLOAD_OFF_BIT];
  assign low_lat = misc_r[LOW_LATENCY_BIT];
  assign complex_on = mode_r[COMPLEX_BIT];

  // Pin synchroniser plus a delayed copy for change detection
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pin_s1_r <= 8'h00;
      pin_s2_r <= 8'h00;
      pin_d_r <= 8'h00;
    end else begin
      pin_s1_r <= pin_freq_pick;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end

  ddcs_cfg_t cfg_nxt;
  logic [3:0] osc_load_nxt;
  logic [3:0][SMP_W-1:0] filt_nxt;
  logic [SMP_W-1:0] byp_a_nxt, byp_b_nxt;

  // Effective configuration, load pulses and sample routing
  always_comb begin
    cfg_nxt.complex_on = complex_on;
    // Image pick is meaningless for real decimation, so gate it
    cfg_nxt.neg_image = load_r[NEG_IMAGE_BIT] & complex_on;
    cfg_nxt.phase_coherent = load_r[PHASE_MODE_BIT];
    cfg_nxt.low_latency = low_lat;
    for (int i = 0; i < 4; i++) begin
      // Register pick or pin pick per filter
      cfg_nxt.freq_pick[i] = reg_pick ? pick_r[2*i+:2]
                                      : pin_s2_r[2*i+:2];
      pin_change[i] = pin_s2_r[2*i+:2] != pin_d_r[2*i+:2];
      filt_nxt[i] = low_lat ? '0
          : pick_src(src_r[2*i+:2], i[0], chan_a_smp, chan_b_smp);
    end
    // Code passes through; 0000 bypass, n gives /2^n downstream
    cfg_nxt.decim[0] = declo_r[3:0];
    cfg_nxt.decim[1] = declo_r[7:4];
    cfg_nxt.decim[2] = dechi_r[3:0];
    cfg_nxt.decim[3] = dechi_r[7:4];
    if (!dcom_r[UNEQUAL_BIT]) begin
      for (int i = 0; i < 4; i++) begin
        cfg_nxt.decim[i] = dcom_r[COMMON_DECIM_LSB+:4];
      end
    end
    // Pin switch loads only in pin mode with autoload enabled
    osc_load_nxt = load_edge;
    if (!reg_pick && !autoload_off) begin
      osc_load_nxt = load_edge | pin_change;
    end
    byp_a_nxt = low_lat ? chan_a_smp : '0;
    byp_b_nxt = low_lat ? chan_b_smp : '0;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      cfg_r <= '0;
      osc_load_r <= 4'h0;
      filt_smp_r <= '0;
      bypass_a_r <= '0;
      bypass_b_r <= '0;
    end else begin
      cfg_r <= cfg_nxt;
      osc_load_r <= osc_load_nxt;
      filt_smp_r <= filt_nxt;
      bypass_a_r <= byp_a_nxt;
      bypass_b_r <= byp_b_nxt;
    end
  end

  // Checks
  default clocking @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_osc0_rise;
    wr_stb && wr.addr == OFF_OSC_LOAD && wr.data[OSC_LOAD_LSB] &&
    !load_r[OSC_LOAD_LSB];
  endsequence
  sequence s_common_rise;
    wr_stb && wr.addr == OFF_OSC_MISC && wr.data[COMMON_LOAD_BIT] &&
    !misc_r[COMMON_LOAD_BIT];
  endsequence

  a_src_own_a: assert property (
    (!low_lat && src_r[1:0] == 2'b00) |=>
      filt_smp_r[0] == $past(chan_a_smp))
    else $error("filter 0 did not take channel A");
  a_src_other_a: assert property (
    (!low_lat && src_r[3:2] == 2'b01) |=>
      filt_smp_r[1] == $past(chan_a_smp))
    else $error("filter 1 did not take channel A");
  a_src_half_sum: assert property (
    (!low_lat && src_r[5:4] == 2'b10) |=>
      filt_smp_r[2] == $past(half_mix(chan_a_smp, chan_b_smp, 1'b0)))
    else $error("filter 2 half sum wrong");
  a_src_half_diff: assert property (
    (!low_lat && src_r[7:6] == 2'b11) |=>
      filt_smp_r[3] == $past(half_mix(chan_a_smp, chan_b_smp, 1'b1)))
    else $error("filter 3 half difference wrong");
  a_osc_load_edge: assert property (
    s_osc0_rise |=> osc_load_r[0] ##1 load_r[OSC_LOAD_LSB])
    else $error("oscillator 0 load edge missed");
  a_common_load_all: assert property (
    s_common_rise |=> osc_load_r == 4'hf)
    else $error("shared load did not hit all oscillators");
  a_load_has_cause: assert property (
    osc_load_r[2] |-> $past(load_edge[2] || pin_change[2]))
    else $error("load pulse without a cause");
  a_neg_image_gate: assert property (
    cfg_r.neg_image |-> cfg_r.complex_on && $past(load_r[NEG_IMAGE_BIT]))
    else $error("negative image active outside complex mode");
  a_phase_mode_wr: assert property (
    (wr_stb && wr.addr == OFF_OSC_LOAD) |=> ##1
      cfg_r.phase_coherent == $past(wr.data[PHASE_MODE_BIT], 2))
    else $error("phase mode not applied");
  a_low_lat_route: assert property (
    low_lat |=> bypass_a_r == $past(chan_a_smp) && filt_smp_r[0] == '0)
    else $error("low latency routing wrong");
  a_pin_no_autoload: assert property (
    (!reg_pick && autoload_off && load_edge == 4'h0) |=> osc_load_r == 4'h0)
    else $error("load pulse with autoload off");
  a_reg_pick_use: assert property (
    reg_pick |=> cfg_r.freq_pick[2] == $past(pick_r[5:4]))
    else $error("register frequency pick not used");
  a_common_decim: assert property (
    !dcom_r[UNEQUAL_BIT] |=> cfg_r.decim[3] == $past(dcom_r[3:0]))
    else $error("common decimation not applied");

endmodule // ddcs_ctrl

// *** ddcs_pkg.sv ***
// Purpose: Shared constants and types for the down-converter source,
//          oscillator load and decimation control block.
// Assumes: Byte-wide registers on a 15-bit serial-port address.
// Notes:   Reserved bits are stored as written and read back unchanged.
package ddcs_pkg;

  // Serial frame layout: 1 read flag, 15 address bits, 8 data bits
  localparam int ADDR_W = 15;
  localparam int FRAME_BITS = 24;
  localparam int ADDR_DONE_BITS = 16;
  localparam logic [4:0] FRAME_BITS_C = 5'h18;
  localparam logic [4:0] ADDR_DONE_C = 5'h10;

  // Register offsets
  localparam logic [14:0] OFF_OUTPUT_MODE = 15'h162;
  localparam logic [14:0] OFF_SOURCE_SEL = 15'h163;
  localparam logic [14:0] OFF_OSC_LOAD = 15'h164;
  localparam logic [14:0] OFF_OSC_MISC = 15'h165;
  localparam logic [14:0] OFF_FREQ_PICK = 15'h166;
  localparam logic [14:0] OFF_DECIM_LOW = 15'h167;
  localparam logic [14:0] OFF_DECIM_HIGH = 15'h168;
  localparam logic [14:0] OFF_DECIM_COMMON = 15'h169;

  // Reset values
  localparam logic [7:0] RST_OUTPUT_MODE = 8'h00;
  localparam logic [7:0] RST_SOURCE_SEL = 8'h00;
  localparam logic [7:0] RST_OSC_LOAD = 8'h00;
  localparam logic [7:0] RST_OSC_MISC = 8'h00;
  localparam logic [7:0] RST_FREQ_PICK = 8'h20;
  localparam logic [7:0] RST_DECIM_LOW = 8'h00;
  localparam logic [7:0] RST_DECIM_HIGH = 8'h00;
  localparam logic [7:0] RST_DECIM_COMMON = 8'h00;

  // Field positions
  localparam int COMPLEX_BIT = 2;
  localparam int PHASE_MODE_BIT = 0;
  localparam int NEG_IMAGE_BIT = 3;
  localparam int OSC_LOAD_LSB = 4;
  localparam int COMMON_LOAD_BIT = 0;
  localparam int REG_PICK_BIT = 1;
  localparam int AUTOLOAD_OFF_BIT = 2;
  localparam int LOW_LATENCY_BIT = 4;
  localparam int UNEQUAL_BIT = 7;
  localparam int COMMON_DECIM_LSB = 0;

  // Filter source selector codes
  typedef enum logic [1:0] {
    SRC_OWN = 2'b00,
    SRC_OTHER = 2'b01,
    SRC_HALF_SUM = 2'b10,
    SRC_HALF_DIFF = 2'b11
  } ddcs_src_t;

  // Register write from the serial port
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
  } ddcs_wr_t;

  // Effective configuration handed to the datapath
  typedef struct packed {
    logic complex_on;
    logic neg_image;
    logic phase_coherent;
    logic low_latency;
    logic [3:0][1:0] freq_pick;
    logic [3:0][3:0] decim;
  } ddcs_cfg_t;

endpackage

// *** ddcs_spi_slave.sv ***
// Purpose: Serial register port, 24-bit frames, oversampled by core_clk.
// Assumes: Serial clock at most an eighth of core_clk; mode 0 framing.
// Notes:   Read data leave on the falling serial clock edge.
`timescale 1ns/10ps
module ddcs_spi_slave
  import ddcs_pkg::*;
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset_n,
  // Serial pins
  input wire logic spi_sclk,
  input wire logic spi_sen_n,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Register side
  input wire logic [7:0] rd_data,
  output logic [14:0] rd_addr_r,
  output ddcs_wr_t wr_r,
  output logic wr_stb_r
);

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SHIFT = 1'b1
  } ddcs_spi_st_t;

  logic [2:0] s1_r, s2_r;
  logic sclk_d_r;
  ddcs_spi_st_t st_r, st_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic [23:0] sh_r, sh_nxt;
  logic [7:0] out_r, out_nxt;
  logic oe_r, oe_nxt, ld_r, ld_nxt;
  logic [14:0] rd_addr_nxt;
  ddcs_wr_t wr_nxt;
  logic wr_stb_nxt;
  logic rise, fall;

  // Two-stage synchronisers; only stage two and its delay feed logic
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      // Idle pin levels: enable high, clock low, so no false edge
      s1_r <= 3'h4;
      s2_r <= 3'h4;
      sclk_d_r <= 1'b0;
    end else begin
      s1_r <= {spi_sen_n, spi_sclk, spi_sdi};
      s2_r <= s1_r;
      sclk_d_r <= s2_r[1];
    end
  end

  assign rise = s2_r[1] && !sclk_d_r;
  assign fall = !s2_r[1] && sclk_d_r;
  assign spi_sdo = out_r[7];
  assign spi_sdo_oe = oe_r;

  // Frame sequencing
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    out_nxt = out_r;
    oe_nxt = oe_r;
    ld_nxt = 1'b0;
    rd_addr_nxt = rd_addr_r;
    wr_nxt = wr_r;
    wr_stb_nxt = 1'b0;
    if (ld_r) begin
      out_nxt = rd_data;
    end
    case (st_r)
      ST_IDLE: begin
        cnt_nxt = 5'h00;
        oe_nxt = 1'b0;
        if (!s2_r[2]) begin
          st_nxt = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (s2_r[2]) begin
          st_nxt = ST_IDLE;
          oe_nxt = 1'b0;
        end else if (rise && cnt_r != FRAME_BITS_C) begin
          sh_nxt = {sh_r[22:0], s2_r[0]};
          cnt_nxt = cnt_r + 5'h01;
          if (cnt_nxt == ADDR_DONE_C) begin
            rd_addr_nxt = sh_nxt[14:0];
            ld_nxt = sh_nxt[15];
            oe_nxt = sh_nxt[15];
          end
          if (cnt_nxt == FRAME_BITS_C && !sh_nxt[23]) begin
            wr_nxt = '{addr: sh_nxt[22:8], data: sh_nxt[7:0]};
            wr_stb_nxt = 1'b1;
          end
        end else if (fall && oe_r && cnt_r > ADDR_DONE_C) begin
          out_nxt = {out_r[6:0], 1'b0};
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_r <= ST_IDLE;
      cnt_r <= 5'h00;
      sh_r <= 24'h000000;
      out_r <= 8'h00;
      oe_r <= 1'b0;
      ld_r <= 1'b0;
      rd_addr_r <= 15'h0000;
      wr_r <= '0;
      wr_stb_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      out_r <= out_nxt;
      oe_r <= oe_nxt;
      ld_r <= ld_nxt;
      rd_addr_r <= rd_addr_nxt;
      wr_r <= wr_nxt;
      wr_stb_r <= wr_stb_nxt;
    end
  end

endmodule // ddcs_spi_slave

// *** tb_top.sv ***
// Purpose: Self-checking bench for the filter source, oscillator load
//          and decimation control block, driven over its serial port.
// Assumes: Serial clock half period of 5 core cycles, within the limit.
// Notes:   Load pulses are counted in the background and checked in bulk.
`timescale 1ns/10ps
module tb_top;
  import ddcs_pkg::*;

  localparam int HP = 5;
  localparam int CYCLE_CEIL = 30000;

  // Design pins
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic spi_sclk = 1'b0;
  logic spi_sen_n = 1'b1;
  logic spi_sdi = 1'b0;
  logic spi_sdo;
  logic spi_sdo_oe;
  logic [7:0] pin_freq_pick = 8'h00;
  logic [15:0] chan_a_smp = 16'h0000;
  logic [15:0] chan_b_smp = 16'h0000;
  logic [3:0][15:0] filt;
  logic [15:0] bypass_a;
  logic [15:0] bypass_b;
  logic [3:0] osc_load_r;
  ddcs_cfg_t cfg;

  // Bench bookkeeping
  int n_fail = 0;
  int samples_checked = 0;
  int cycles = 0;
  int ld_cnt [4] = '{0, 0, 0, 0};
  int ld_exp [4] = '{0, 0, 0, 0};
  logic [15:0] pa [2] = '{16'h7ffe, 16'hfffd};
  logic [15:0] pb [2] = '{16'h8003, 16'h0000};
  logic oe_rd;

  ddcs_ctrl #(.SMP_W(16)) u_ddcs_ctrl (
    .core_clk(core_clk), .reset_n(reset_n),
    .spi_sclk(spi_sclk), .spi_sen_n(spi_sen_n), .spi_sdi(spi_sdi),
    .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .pin_freq_pick(pin_freq_pick),
    .chan_a_smp(chan_a_smp), .chan_b_smp(chan_b_smp),
    .filt_smp_r(filt), .bypass_a_r(bypass_a), .bypass_b_r(bypass_b),
    .osc_load_r(osc_load_r), .cfg_r(cfg)
  );

  // Free-running core clock
  always #5 core_clk = ~core_clk;

  // Count every cycle a load line is high, so a long pulse shows up
  always @(posedge core_clk) begin
    if (reset_n) begin
      for (int i = 0; i < 4; i++) begin
        if (osc_load_r[i] === 1'b1) ld_cnt[i]++;
      end
    end
  end

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == CYCLE_CEIL) begin
      n_fail++;
      close_out();
    end
  end

  task automatic close_out;
    if (n_fail == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One 24-bit frame; pins move only just after a core edge
  task automatic spi_xfer(input logic rd, input logic [14:0] a,
                          input logic [7:0] d, output logic [7:0] q);
    logic [23:0] f;
    f = {rd, a, d};
    q = 8'h00;
    @(posedge core_clk);
    spi_sen_n <= 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sdi <= f[i];
      repeat (HP) @(posedge core_clk);
      if (i < 8) q[i] = spi_sdo;
      if (i == 0) oe_rd = spi_sdo_oe;
      spi_sclk <= 1'b1;
      repeat (HP) @(posedge core_clk);
      spi_sclk <= 1'b0;
    end
    repeat (HP) @(posedge core_clk);
    spi_sen_n <= 1'b1;
    // Gap between frames, also lets cfg settle
    repeat (6) @(posedge core_clk);
  endtask

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    logic [7:0] q;
    spi_xfer(1'b0, a, d, q);
    chk({15'h0, oe_rd}, 16'h0000);
  endtask

  task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
    logic [7:0] q;
    spi_xfer(1'b1, a, 8'h00, q);
    chk({8'h00, q}, {8'h00, exp});
    chk({15'h0, oe_rd}, 16'h0001);
    chk({15'h0, spi_sdo_oe}, 16'h0000);
  endtask

  // Add the expected new pulses, then compare all four counters
  task automatic ld_chk(input logic [3:0] inc);
    for (int i = 0; i < 4; i++) begin
      ld_exp[i] += inc[i];
      chk(ld_cnt[i][15:0], ld_exp[i][15:0]);
    end
  endtask

  task automatic pick_chk(input logic [7:0] v);
    for (int i = 0; i < 4; i++) begin
      chk({14'h0, cfg.freq_pick[i]}, {14'h0, v[2*i+:2]});
    end
  endtask

  task automatic pins(input logic [7:0] v);
    @(posedge core_clk);
    pin_freq_pick <= v;
    // Two sync flops, then the register stage
    repeat (8) @(posedge core_clk);
  endtask

  // Expected filter input; wide sum keeps the extreme pair exact
  function automatic logic [15:0] src_exp(int i, logic [1:0] c,
                                          logic [15:0] a, logic [15:0] b);
    logic signed [16:0] s;
    s = (c == 2'b10) ? $signed({a[15], a}) + $signed({b[15], b})
                     : $signed({a[15], a}) - $signed({b[15], b});
    s = s >>> 1;
    case (c)
      2'b00: return i[0] ? b : a;
      2'b01: return i[0] ? a : b;
      default: return s[15:0];
    endcase
  endfunction

  initial begin
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge core_clk);

    // Reset values and an unmapped place
    rd_chk(OFF_SOURCE_SEL, 8'h00);
    rd_chk(OFF_OSC_LOAD, 8'h00);
    rd_chk(OFF_OSC_MISC, 8'h00);
    rd_chk(OFF_FREQ_PICK, 8'h20);
    rd_chk(OFF_DECIM_LOW, 8'h00);
    rd_chk(OFF_DECIM_HIGH, 8'h00);
    wr(15'h170, 8'h5a);
    rd_chk(15'h170, 8'h00);
    ld_chk(4'h0);

    // Every source code on two sample pairs, one with odd negative sum
    for (int p = 0; p < 2; p++) begin
      chan_a_smp <= pa[p];
      chan_b_smp <= pb[p];
      for (int c = 0; c < 4; c++) begin
        wr(OFF_SOURCE_SEL, {4{c[1:0]}});
        for (int i = 0; i < 4; i++) begin
          chk(filt[i], src_exp(i, c[1:0], pa[p], pb[p]));
        end
      end
    end
    rd_chk(OFF_SOURCE_SEL, 8'hff);

    // Low latency routes raw samples out and starves the filters
    wr(OFF_OSC_MISC, 8'h10);
    chk(bypass_a, pa[1]);
    chk(bypass_b, pb[1]);
    chk(filt[2], 16'h0000);
    chk({15'h0, cfg.low_latency}, 16'h0001);
    wr(OFF_OSC_MISC, 8'h00);
    chk(bypass_a, 16'h0000);
    chk(filt[0], src_exp(0, 2'b11, pa[1], pb[1]));

    // Per-oscillator and shared loads; reserved bits stay zero
    wr(OFF_OSC_LOAD, 8'h10);
    ld_chk(4'h1);
    wr(OFF_OSC_LOAD, 8'hf0);
    ld_chk(4'he);
    wr(OFF_OSC_LOAD, 8'hf0);
    ld_chk(4'h0);
    // Clear before the next rise, as software must
    wr(OFF_OSC_LOAD, 8'h00);
    ld_chk(4'h0);
    wr(OFF_OSC_MISC, 8'h01);
    ld_chk(4'hf);
    wr(OFF_OSC_MISC, 8'h01);
    ld_chk(4'h0);
    wr(OFF_OSC_MISC, 8'h00);
    ld_chk(4'h0);

    // Phase mode, and negative image gated by complex decimation
    wr(OFF_OSC_LOAD, 8'h09);
    chk({15'h0, cfg.phase_coherent}, 16'h0001);
    chk({15'h0, cfg.neg_image}, 16'h0000);
    wr(OFF_OUTPUT_MODE, 8'h04);
    chk({15'h0, cfg.complex_on}, 16'h0001);
    chk({15'h0, cfg.neg_image}, 16'h0001);
    wr(OFF_OSC_LOAD, 8'h00);
    chk({15'h0, cfg.phase_coherent}, 16'h0000);
    wr(OFF_OUTPUT_MODE, 8'h00);
    chk({15'h0, cfg.complex_on}, 16'h0000);
    ld_chk(4'h0);

    // Pin picks with autoload on, then off, then register picks
    pins(8'h1b);
    pick_chk(8'h1b);
    ld_chk(4'h7);
    wr(OFF_OSC_MISC, 8'h04);
    pins(8'he4);
    pick_chk(8'he4);
    ld_chk(4'h0);
    wr(OFF_OSC_MISC, 8'h02);
    pick_chk(8'h20);
    wr(OFF_FREQ_PICK, 8'h1b);
    pick_chk(8'h1b);
    pins(8'h00);
    pick_chk(8'h1b);
    ld_chk(4'h0);

    // Common factor until unequal decimation is switched on
    wr(OFF_DECIM_COMMON, 8'h05);
    wr(OFF_DECIM_LOW, 8'h21);
    wr(OFF_DECIM_HIGH, 8'hf0);
    chk(cfg.decim, 16'h5555);
    wr(OFF_DECIM_COMMON, 8'h85);
    chk(cfg.decim, 16'hf021);
    rd_chk(OFF_DECIM_HIGH, 8'hf0);
    wr(OFF_DECIM_COMMON, 8'h0f);
    chk(cfg.decim, 16'hffff);

    close_out();
  end
endmodule // tb_top
